// *** logic/pattern_out_pkg.sv ***
/*
 Constants, register offsets, reset values and carriers for the triggered pattern output unit.
 Assumes an 8-bit special-register access port with 16-bit addresses on one clock.
*/
package pattern_out_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CH0_W  = 8;
   localparam int unsigned CH1_W  = 6;
   localparam int unsigned HALF_W = 4;

   localparam logic [15:0] PORT3_DIRECTION_ADDR    = 16'hff23;
   localparam logic [15:0] PATTERN_CH0_CONTROL_ADDR = 16'hff87;
   localparam logic [15:0] PATTERN_CH1_SELECT_ADDR  = 16'hff9e;
   localparam logic [15:0] PATTERN_CH1_CONTROL_ADDR = 16'hff9f;
   localparam logic [15:0] PATTERN_CH0_BUF_LO_ADDR  = 16'hff30;
   localparam logic [15:0] PATTERN_CH0_BUF_HI_ADDR  = 16'hff31;
   localparam logic [15:0] PATTERN_CH1_BUF_LO_ADDR  = 16'hff32;
   localparam logic [15:0] PATTERN_CH1_BUF_HI_ADDR  = 16'hff33;
   localparam logic [15:0] PATTERN_CH0_SELECT_ADDR  = 16'hff86;
   localparam logic [15:0] PORT3_DATA_ADDR          = 16'hff03;

   localparam logic [7:0] PORT3_DIRECTION_RST = 8'hff;
   localparam logic [7:0] CH0_SELECT_RST      = 8'h00;
   localparam logic [5:0] CH1_SELECT_RST      = 6'h00;
   localparam logic [7:0] PORT3_DATA_RST      = 8'h00;

   localparam int unsigned CTRL_OPERATE_BIT = 7;
   localparam int unsigned CTRL_EDGE_BIT    = 6;
   localparam int unsigned CTRL_WIDTH_BIT   = 5;
   localparam int unsigned CTRL_EXT_BIT     = 4;

   localparam int unsigned SYNC_STAGES = 2;

   typedef struct packed {
      logic operate;
      logic edge_rising;
      logic width_full;
      logic ext_trigger;
   } ch0_ctrl_s;

   typedef struct packed {
      logic operate;
      logic width_wide;
   } ch1_ctrl_s;

   localparam ch0_ctrl_s CH0_CTRL_RST = '0;
   localparam ch1_ctrl_s CH1_CTRL_RST = '0;

   typedef struct packed {
      logic                     wr;
      logic                     rd;
      logic [ADDR_W-1:0]        addr;
      logic [DATA_W-1:0]        wdata;
   } reg_req_s;

endpackage

// *** logic/pin_sync.sv ***
/*
 Two-stage synchroniser for a group of asynchronous pin levels.
 Assumes the inputs are levels from outside the clock domain.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   import pattern_out_pkg::*;

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// *** logic/triggered_pattern_output_port.sv ***
/*
 Two-channel triggered pattern output unit with its register file and port 3 pin control.
 Assumes timer triggers are one-cycle pulses on this clock and the external trigger is a pin.
*/
`timescale 1ns/1ps
// Behaviour
// - Selected trigger copies the pattern buffer into the output latch by hardware.
// - Channel 0 split mode: each half address writes only its own nibble.
// - Channel 0 full mode: a write to either address loads both halves.
// - Channel 0 reads give high nibble upper, low nibble lower, always.
// - Buffer read bits not selected for pattern output read as zero.
// - Channel 1 narrow mode: only the low 4 bits written; upper ignored.
// - Channel 1 wide mode: either address loads and reads all 6 bits.
// - Port direction register, 0 output, 1 input, resets to all ones.
// - Channel 0 per-bit select, pattern or ordinary port, cleared at reset.
// - Channel 1 per-bit select, 1 pattern, 0 forces zero, cleared at reset.
// - Channel 0 disabled drives zero on pattern pins; enabled allows transfers.
// - Channel 0 width bit: 0 two 4-bit halves, 1 one 8-bit channel.
// - External-trigger bit set makes the external input the channel 0 low-half trigger in split mode, the whole-channel trigger in full mode.
// - Channel 0 trigger routing per width and external-trigger settings.
// - Channel 1 control holds operate bit 7, width bit 5, others zero.
// - Channel 1 transfers on the second compare; width bit 0 narrow, 1 wide.
// - Ordinary port pins act as plain I/O, unaffected by pattern transfers.
module triggered_pattern_output_port (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire pattern_out_pkg::reg_req_s       reg_req,
   output logic [pattern_out_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic                            timer5_trigger,
   input  wire logic                            timer0_compare_trigger,
   input  wire logic                            timer0_second_compare_trigger,
   input  wire logic                            external_trigger_input,
   input  wire logic [pattern_out_pkg::CH0_W-1:0] port3_in,
   output logic [pattern_out_pkg::CH0_W-1:0]    ch0_pattern_pin,
   output logic [pattern_out_pkg::CH0_W-1:0]    ch0_pattern_pin_oe,
   output logic [pattern_out_pkg::CH1_W-1:0]    ch1_pattern_pin
);
   import pattern_out_pkg::*;

   logic [CH0_W-1:0]  port3_direction_ff;
   logic [CH0_W-1:0]  port3_data_ff;
   logic [CH0_W-1:0]  ch0_select_ff;
   logic [CH1_W-1:0]  ch1_select_ff;
   ch0_ctrl_s         ch0_ctrl_ff;
   ch1_ctrl_s         ch1_ctrl_ff;
   logic [HALF_W-1:0] ch0_buf_lo_ff;
   logic [HALF_W-1:0] ch0_buf_hi_ff;
   logic [HALF_W-1:0] ch1_buf_lo_ff;
   logic [1:0]        ch1_buf_hi_ff;
   logic [CH0_W-1:0]  ch0_latch_ff;
   logic [CH1_W-1:0]  ch1_latch_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic              ext_prev_ff;
   logic [CH0_W:0]    synced;
   logic              ext_level;
   logic [CH0_W-1:0]  port3_level;
   logic              ext_pulse;
   logic              load_hi;
   logic              load_lo;
   logic              ch1_load;
   logic              wr;
   logic              rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;

   assign wr    = reg_req.wr;
   assign rd    = reg_req.rd;
   assign addr  = reg_req.addr;
   assign wdata = reg_req.wdata;

   pin_sync #(
      .WIDTH (CH0_W + 1)
   ) u_pin_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({external_trigger_input, port3_in}),
      .sync_out (synced)
   );

   assign ext_level   = synced[CH0_W];
   assign port3_level = synced[CH0_W-1:0];

   always_ff @(posedge clk)
   begin
      if (rst)
         ext_prev_ff <= 1'b0;
      else
         ext_prev_ff <= ext_level;
   end

   // Changing the edge select while the input is static creates no stray pulse.
   assign ext_pulse = ch0_ctrl_ff.edge_rising ? (ext_level & ~ext_prev_ff)
                                              : (~ext_level & ext_prev_ff);

   // Trigger routing for the two channel 0 halves.
   always_comb
   begin
      load_hi = 1'b0;
      load_lo = 1'b0;
      if (ch0_ctrl_ff.operate)
      begin
         case ({ch0_ctrl_ff.width_full, ch0_ctrl_ff.ext_trigger})
            2'b00:
            begin
               load_hi = timer5_trigger;
               load_lo = timer0_compare_trigger;
            end
            2'b01:
            begin
               load_hi = timer0_compare_trigger;
               load_lo = ext_pulse;
            end
            2'b10:
            begin
               load_hi = timer0_compare_trigger;
               load_lo = timer0_compare_trigger;
            end
            default:
            begin
               load_hi = ext_pulse;
               load_lo = ext_pulse;
            end
         endcase
      end
   end

   assign ch1_load = ch1_ctrl_ff.operate & timer0_second_compare_trigger;

   // Control, select and port 3 registers.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         port3_direction_ff <= PORT3_DIRECTION_RST;
         port3_data_ff      <= PORT3_DATA_RST;
         ch0_select_ff      <= CH0_SELECT_RST;
         ch1_select_ff      <= CH1_SELECT_RST;
         ch0_ctrl_ff        <= CH0_CTRL_RST;
         ch1_ctrl_ff        <= CH1_CTRL_RST;
      end
      else if (wr)
      begin
         case (addr)
            PORT3_DIRECTION_ADDR:
               port3_direction_ff <= wdata;
            PORT3_DATA_ADDR:
               port3_data_ff <= wdata;
            PATTERN_CH0_SELECT_ADDR:
               ch0_select_ff <= wdata;
            PATTERN_CH1_SELECT_ADDR:
               ch1_select_ff <= wdata[CH1_W-1:0];
            PATTERN_CH0_CONTROL_ADDR:
               ch0_ctrl_ff <= {wdata[CTRL_OPERATE_BIT], wdata[CTRL_EDGE_BIT],
                               wdata[CTRL_WIDTH_BIT], wdata[CTRL_EXT_BIT]};
            PATTERN_CH1_CONTROL_ADDR:
               ch1_ctrl_ff <= {wdata[CTRL_OPERATE_BIT], wdata[CTRL_WIDTH_BIT]};
            default:
               ;
         endcase
      end
   end

   // Pattern buffers; contents are undefined-free by clearing them at reset.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ch0_buf_lo_ff <= '0;
         ch0_buf_hi_ff <= '0;
         ch1_buf_lo_ff <= '0;
         ch1_buf_hi_ff <= '0;
      end
      else if (wr)
      begin
         if (addr == PATTERN_CH0_BUF_LO_ADDR || addr == PATTERN_CH0_BUF_HI_ADDR)
         begin
            if (ch0_ctrl_ff.width_full)
            begin
               ch0_buf_hi_ff <= wdata[7:4];
               ch0_buf_lo_ff <= wdata[3:0];
            end
            else if (addr == PATTERN_CH0_BUF_LO_ADDR)
               ch0_buf_lo_ff <= wdata[3:0];
            else
               ch0_buf_hi_ff <= wdata[7:4];
         end
         if (ch1_ctrl_ff.width_wide &&
             (addr == PATTERN_CH1_BUF_LO_ADDR || addr == PATTERN_CH1_BUF_HI_ADDR))
         begin
            ch1_buf_hi_ff <= wdata[5:4];
            ch1_buf_lo_ff <= wdata[3:0];
         end
         else if (!ch1_ctrl_ff.width_wide && addr == PATTERN_CH1_BUF_LO_ADDR)
            ch1_buf_lo_ff <= wdata[3:0];
      end
   end

   // Output latches take the old buffer value even if software writes in the trigger cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ch0_latch_ff <= '0;
         ch1_latch_ff <= '0;
      end
      else
      begin
         if (load_hi)
            ch0_latch_ff[7:4] <= ch0_buf_hi_ff;
         if (load_lo)
            ch0_latch_ff[3:0] <= ch0_buf_lo_ff;
         if (ch1_load && ch1_ctrl_ff.width_wide)
            ch1_latch_ff <= {ch1_buf_hi_ff, ch1_buf_lo_ff};
         else if (ch1_load)
            ch1_latch_ff[3:0] <= ch1_buf_lo_ff;
      end
   end

   // Read image, answered one cycle after the read strobe.
   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (rd)
      begin
         case (addr)
            PORT3_DIRECTION_ADDR:
               nxt_rdata = port3_direction_ff;
            PORT3_DATA_ADDR:
               nxt_rdata = (port3_direction_ff & port3_level) |
                           (~port3_direction_ff & port3_data_ff);
            PATTERN_CH0_SELECT_ADDR:
               nxt_rdata = ch0_select_ff;
            PATTERN_CH1_SELECT_ADDR:
               nxt_rdata = {2'h0, ch1_select_ff};
            PATTERN_CH0_CONTROL_ADDR:
               nxt_rdata = {ch0_ctrl_ff, 4'h0};
            PATTERN_CH1_CONTROL_ADDR:
               nxt_rdata = {ch1_ctrl_ff.operate, 1'b0, ch1_ctrl_ff.width_wide, 5'h00};
            PATTERN_CH0_BUF_LO_ADDR, PATTERN_CH0_BUF_HI_ADDR:
               nxt_rdata = {ch0_buf_hi_ff, ch0_buf_lo_ff} & ch0_select_ff;
            PATTERN_CH1_BUF_LO_ADDR, PATTERN_CH1_BUF_HI_ADDR:
               if (ch1_ctrl_ff.width_wide)
                  nxt_rdata = {2'h0, ch1_buf_hi_ff, ch1_buf_lo_ff & ch1_select_ff[3:0]}
                              & {2'h0, ch1_select_ff};
               else
                  nxt_rdata = {4'h0, ch1_buf_lo_ff & ch1_select_ff[3:0]};
            default:
               nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= nxt_rdata;
   end

   assign reg_rdata = rdata_ff;

   // Pin drive: pattern bits show the latch only while enabled, port bits show the port latch.
   assign ch0_pattern_pin = (ch0_select_ff & ch0_latch_ff & {CH0_W{ch0_ctrl_ff.operate}})
                            | (~ch0_select_ff & port3_data_ff);
   assign ch0_pattern_pin_oe = ~port3_direction_ff;
   assign ch1_pattern_pin = ch1_select_ff & ch1_latch_ff
                            & {CH1_W{ch1_ctrl_ff.operate}};

   sequence split_t5_seq;
      ch0_ctrl_ff.operate && !ch0_ctrl_ff.width_full && !ch0_ctrl_ff.ext_trigger
      && timer5_trigger && !timer0_compare_trigger;
   endsequence

   sequence full_ext_seq;
      ch0_ctrl_ff.operate && ch0_ctrl_ff.width_full && ch0_ctrl_ff.ext_trigger && ext_pulse;
   endsequence

   split_high_a: assert property (@(posedge clk) disable iff (rst)
      split_t5_seq |=> ch0_latch_ff[7:4] == $past(ch0_buf_hi_ff)
                       && ch0_latch_ff[3:0] == $past(ch0_latch_ff[3:0]))
      else $error("Split high half did not load on timer5 trigger.");

   full_ext_a: assert property (@(posedge clk) disable iff (rst)
      full_ext_seq |=> ch0_latch_ff == $past({ch0_buf_hi_ff, ch0_buf_lo_ff}))
      else $error("Full width external trigger did not load latch.");

   split_write_a: assert property (@(posedge clk) disable iff (rst)
      wr && addr == PATTERN_CH0_BUF_LO_ADDR && !ch0_ctrl_ff.width_full
      |=> ch0_buf_hi_ff == $past(ch0_buf_hi_ff) && ch0_buf_lo_ff == $past(wdata[3:0]))
      else $error("Split low write touched high half.");

   full_write_a: assert property (@(posedge clk) disable iff (rst)
      wr && addr == PATTERN_CH0_BUF_HI_ADDR && ch0_ctrl_ff.width_full
      |=> {ch0_buf_hi_ff, ch0_buf_lo_ff} == $past(wdata))
      else $error("Full width write did not load both halves.");

   ch0_read_a: assert property (@(posedge clk) disable iff (rst)
      rd && !wr && addr == PATTERN_CH0_BUF_LO_ADDR
      |=> reg_rdata == $past({ch0_buf_hi_ff, ch0_buf_lo_ff} & ch0_select_ff))
      else $error("Channel 0 buffer read image wrong.");

   narrow_ignore_a: assert property (@(posedge clk) disable iff (rst)
      wr && addr == PATTERN_CH1_BUF_HI_ADDR && !ch1_ctrl_ff.width_wide
      |=> ch1_buf_hi_ff == $past(ch1_buf_hi_ff) && ch1_buf_lo_ff == $past(ch1_buf_lo_ff))
      else $error("Narrow mode high write was not ignored.");

   direction_reset_a: assert property (@(posedge clk)
      rst |=> port3_direction_ff == 8'hff && ch0_pattern_pin_oe == 8'h00)
      else $error("Direction register not all ones after reset.");

   disabled_zero_a: assert property (@(posedge clk) disable iff (rst)
      !ch0_ctrl_ff.operate |-> (ch0_pattern_pin & ch0_select_ff) == 8'h00)
      else $error("Disabled channel 0 drove a pattern pin high.");

   ctrl1_read_a: assert property (@(posedge clk) disable iff (rst)
      rd && addr == PATTERN_CH1_CONTROL_ADDR |=> (reg_rdata & 8'h5f) == 8'h00)
      else $error("Channel 1 control read unused bits as nonzero.");

   ch1_wide_a: assert property (@(posedge clk) disable iff (rst)
      ch1_load && ch1_ctrl_ff.width_wide
      |=> ch1_latch_ff == $past({ch1_buf_hi_ff, ch1_buf_lo_ff}))
      else $error("Channel 1 wide transfer failed.");

   port_pin_a: assert property (@(posedge clk) disable iff (rst)
      ((ch0_pattern_pin ^ port3_data_ff) & ~ch0_select_ff) == 8'h00)
      else $error("Ordinary port pin does not follow port latch.");

   ch1_narrow_a: assert property (@(posedge clk) disable iff (rst)
      ch1_load && !ch1_ctrl_ff.width_wide
      |=> ch1_latch_ff == {$past(ch1_latch_ff[5:4]), $past(ch1_buf_lo_ff)})
      else $error("Channel 1 narrow transfer touched the upper bits.");

   ch1_unselected_a: assert property (@(posedge clk) disable iff (rst)
      (ch1_pattern_pin & ~ch1_select_ff) == 6'h00)
      else $error("Unselected channel 1 output was not zero.");

endmodule

// *** testbench/stepper_load.sv ***
/*
 External load model for the port 3 pattern pins and the channel 1 pattern outputs.
 Assumes the load drives port 3 wires only where the device leaves them undriven.
*/
`timescale 1ns/1ps
module stepper_load (
   input  wire logic       clk,
   input  wire logic [7:0] ch0_pattern_pin,
   input  wire logic [7:0] ch0_pattern_pin_oe,
   input  wire logic [5:0] ch1_pattern_pin,
   input  wire logic [7:0] load_level,
   output logic      [7:0] wire_level,
   output logic      [5:0] coil_ff
);
   // Each wire shows the device where its enable is high, else the load's own level.
   always_comb
   begin
      wire_level = (ch0_pattern_pin_oe & ch0_pattern_pin) | (~ch0_pattern_pin_oe & load_level);
   end

   // The load registers the channel 1 pattern as a coil driver would.
   always_ff @(posedge clk)
   begin
      coil_ff <= ch1_pattern_pin;
   end
endmodule

// *** testbench/tb_triggered_pattern_output_port.sv ***
/*
 Self-checking bench for the triggered pattern output unit, driven through its register port.
 Assumes the design package, its register offsets and one 200 MHz clock with synchronous reset.
*/
`timescale 1ns/1ps
module tb_triggered_pattern_output_port;
   import pattern_out_pkg::*;
   logic       clk;
   logic       rst;
   reg_req_s   req;
   logic [7:0] reg_rdata;
   logic       t5;
   logic       t0;
   logic       t0b;
   logic       ext;
   logic [7:0] port3_in;
   logic [7:0] pin;
   logic [7:0] oe;
   logic [5:0] ch1;
   logic [5:0] coil;
   int         fails;
   int         check_count;
   int         cycles;

   triggered_pattern_output_port triggered_pattern_output_port_i (
      .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
      .timer5_trigger(t5), .timer0_compare_trigger(t0),
      .timer0_second_compare_trigger(t0b), .external_trigger_input(ext),
      .port3_in(port3_in), .ch0_pattern_pin(pin), .ch0_pattern_pin_oe(oe),
      .ch1_pattern_pin(ch1));

   stepper_load stepper_load_i (
      .clk(clk), .ch0_pattern_pin(pin), .ch0_pattern_pin_oe(oe), .ch1_pattern_pin(ch1),
      .load_level(8'h5c), .wire_level(port3_in), .coil_ff(coil));

   always #2.5 clk = ~clk;

   // A hung run is cut short here so the verdict is still printed.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      @(negedge clk);
      check(reg_rdata, exp, "register read");
   endtask

   // Triggers are one-cycle pulses; the latch is looked at two edges later.
   task automatic pulse(input int which);
      @(negedge clk);
      t5 = (which == 5);
      t0 = (which == 0);
      t0b = (which == 1);
      @(negedge clk);
      t5 = 1'b0;
      t0 = 1'b0;
      t0b = 1'b0;
      @(negedge clk);
   endtask

   // The external pin is synchronised, so it is given several cycles to act.
   task automatic set_ext(input logic v);
      @(negedge clk);
      ext = v;
      repeat (8) @(negedge clk);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, fails);
   endtask

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      req = '0;
      {t5, t0, t0b} = 3'b000;
      ext = 1'b1;
      fails = 0;
      check_count = 0;
      cycles = 0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check(oe, 8'h00, "enables after reset");
      rdc(PORT3_DIRECTION_ADDR, 8'hff);
      rdc(PATTERN_CH0_CONTROL_ADDR, 8'h00);
      rdc(PATTERN_CH0_SELECT_ADDR, 8'h00);
      rdc(PATTERN_CH1_SELECT_ADDR, 8'h00);
      rdc(PATTERN_CH1_CONTROL_ADDR, 8'h00);
      rdc(16'hff00, 8'h00);
      wr(PATTERN_CH0_CONTROL_ADDR, 8'hff);
      rdc(PATTERN_CH0_CONTROL_ADDR, 8'hf0);
      end_test("reset");
      // Pins go to output mode before any pattern is selected on them.
      wr(PORT3_DIRECTION_ADDR, 8'h00);
      check(oe, 8'hff, "enables");
      wr(PATTERN_CH0_SELECT_ADDR, 8'hff);
      wr(PATTERN_CH0_CONTROL_ADDR, 8'ha0);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h5a);
      rdc(PATTERN_CH0_BUF_HI_ADDR, 8'h5a);
      pulse(0);
      check(pin, 8'h5a, "full transfer");
      wr(PATTERN_CH0_BUF_HI_ADDR, 8'h33);
      pulse(5);
      set_ext(1'b0);
      set_ext(1'b1);
      check(pin, 8'h5a, "full ignores others");
      end_test("full width");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'h80);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'hf1);
      wr(PATTERN_CH0_BUF_HI_ADDR, 8'h2f);
      rdc(PATTERN_CH0_BUF_HI_ADDR, 8'h21);
      rdc(PATTERN_CH0_BUF_LO_ADDR, 8'h21);
      pulse(0);
      check(pin, 8'h51, "split low half");
      pulse(5);
      check(pin, 8'h21, "split high half");
      end_test("split");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'h90);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h07);
      wr(PATTERN_CH0_BUF_HI_ADDR, 8'h80);
      pulse(0);
      check(pin, 8'h81, "split ext high");
      set_ext(1'b0);
      check(pin, 8'h87, "falling edge");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'hd0);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h0c);
      set_ext(1'b1);
      check(pin, 8'h8c, "rising edge");
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h03);
      set_ext(1'b0);
      check(pin, 8'h8c, "falling ignored");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'hb0);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h96);
      set_ext(1'b1);
      set_ext(1'b0);
      check(pin, 8'h96, "full ext");
      end_test("external");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'ha0);
      wr(PATTERN_CH0_SELECT_ADDR, 8'h0f);
      wr(PORT3_DATA_ADDR, 8'ha0);
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h77);
      rdc(PATTERN_CH0_BUF_LO_ADDR, 8'h07);
      pulse(0);
      check(pin, 8'ha7, "port bits kept");
      wr(PATTERN_CH0_CONTROL_ADDR, 8'h20);
      check(pin, 8'ha0, "disabled zero");
      wr(PATTERN_CH0_BUF_LO_ADDR, 8'h12);
      pulse(0);
      wr(PATTERN_CH0_CONTROL_ADDR, 8'ha0);
      check(pin, 8'ha7, "disabled ignores");
      // Upper pins become inputs and show the load; the extra write lets the syncs settle.
      wr(PORT3_DIRECTION_ADDR, 8'hf0);
      check(oe, 8'h0f, "upper pins released");
      wr(PORT3_DATA_ADDR, 8'h05);
      rdc(PORT3_DATA_ADDR, 8'h55);
      end_test("port and disable");
      wr(PATTERN_CH1_CONTROL_ADDR, 8'hff);
      rdc(PATTERN_CH1_CONTROL_ADDR, 8'ha0);
      wr(PATTERN_CH1_SELECT_ADDR, 8'h3f);
      wr(PATTERN_CH1_BUF_LO_ADDR, 8'h2d);
      rdc(PATTERN_CH1_BUF_HI_ADDR, 8'h2d);
      pulse(1);
      check({2'b00, ch1}, 8'h2d, "wide transfer");
      check({2'b00, coil}, 8'h2d, "load coil pattern");
      wr(PATTERN_CH1_CONTROL_ADDR, 8'h80);
      wr(PATTERN_CH1_BUF_HI_ADDR, 8'h3f);
      wr(PATTERN_CH1_BUF_LO_ADDR, 8'h05);
      rdc(PATTERN_CH1_BUF_LO_ADDR, 8'h05);
      pulse(1);
      check({2'b00, ch1}, 8'h25, "narrow transfer");
      wr(PATTERN_CH1_CONTROL_ADDR, 8'ha0);
      wr(PATTERN_CH1_SELECT_ADDR, 8'h0f);
      check({2'b00, ch1}, 8'h05, "unselected zero");
      rdc(PATTERN_CH1_BUF_HI_ADDR, 8'h05);
      wr(PATTERN_CH1_CONTROL_ADDR, 8'h00);
      check({2'b00, ch1}, 8'h00, "ch1 disabled");
      end_test("channel 1");
      stop_test();
   end
endmodule
